// [common/pwr_seq_pkg.sv]
// Shared constants, register map and carrier types of the power event sequencer
package pwr_seq_pkg;

	// ----------------------------------------------------------------
	// Clock and times
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned DEBOUNCE_MS    = 16;
	localparam int unsigned OVERRIDE_S     = 4;
	localparam int unsigned RST_HOLD_MS    = 5;
	localparam int unsigned GRACE_MS       = 2;
	localparam int unsigned MIN_SLEEP_MS   = 1000;
	localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int unsigned OVERRIDE_CYC   = OVERRIDE_S * CLK_HZ;
	localparam int unsigned RST_HOLD_CYC   = RST_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned GRACE_CYC      = GRACE_MS * (CLK_HZ / 1000);
	localparam int unsigned MIN_SLEEP_CYC  = MIN_SLEEP_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_SLEEP  = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_LEVEL  = 4'hc;

	// Control bits
	localparam int CTRL_STAY_OFF  = 0;
	localparam int CTRL_SCI_SEL   = 1;
	localparam int CTRL_BTN_IRQ   = 2;
	localparam int CTRL_GBL_MGMT  = 3;
	localparam int CTRL_MIN_SLEEP = 4;
	localparam int CTRL_FULL_RST  = 5;
	localparam int CTRL_ALARM_EN  = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Sleep command bits (write only, self clearing)
	localparam int SLEEP_S5 = 0;
	localparam int SLEEP_S4 = 1;

	// Status bits (write one to clear)
	localparam int STS_BTN     = 0;
	localparam int STS_ALARM   = 1;
	localparam int STS_CORE_PF = 2;
	localparam int STS_SUS_PF  = 3;
	localparam int STS_BUS0    = 4;
	localparam logic [4:0] STS_RESET = 5'h00;

	// Level register bits
	localparam int LVL_BTN     = 0;
	localparam int LVL_STATE   = 2;
	localparam int LVL_PLT_RST = 4;
	localparam int LVL_STRETCH = 5;
	localparam int LVL_RB_BUSY = 6;

	localparam int BUS0_WIDTH = 4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PS_G3 = 2'b00,
		PS_S0 = 2'b01,
		PS_S4 = 2'b10,
		PS_S5 = 2'b11
	} power_state_t;

	typedef enum logic [1:0] {
		RB_IDLE  = 2'b00,
		RB_WAIT  = 2'b01,
		RB_HOLD  = 2'b10,
		RB_BLOCK = 2'b11
	} rst_btn_state_t;

	typedef struct packed {
		logic power_button_n;
		logic reset_button_n;
		logic core_power_good;
		logic suspend_well_reset_n;
	} board_in_t;

	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} avmm_req_t;

endpackage : pwr_seq_pkg

// [logic/pwr_debounce.sv]
// Two-flop synchroniser and stable-level debouncer for an active-low button
`timescale 1ns/1ps
module pwr_debounce #(
	parameter int unsigned CYCLES = pwr_seq_pkg::DEBOUNCE_CYC
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic button_n,
	output logic      pressed
);

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        level;
		logic [31:0] cnt;
	} deb_state_t;

	deb_state_t state_reg;
	deb_state_t state_next;

	// ----------------------------------------------------------------
	// Filter
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.s1 = ~button_n;
		state_next.s2 = state_reg.s1;
		if (state_reg.s2 == state_reg.level) begin
			state_next.cnt = 32'h0;
		end else if (state_reg.cnt == CYCLES - 1) begin
			state_next.level = state_reg.s2;
			state_next.cnt = 32'h0;
		end else begin
			state_next.cnt = state_reg.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pressed = state_reg.level;

endmodule : pwr_debounce

// [logic/power_event_sequencer.sv]
// Power event sequencer: power failure policy, buttons, reset and wake status
`timescale 1ns/1ps
module power_event_sequencer #(
	parameter int unsigned DEBOUNCE_CYCLES  = pwr_seq_pkg::DEBOUNCE_CYC,
	parameter int unsigned OVERRIDE_CYCLES  = pwr_seq_pkg::OVERRIDE_CYC,
	parameter int unsigned RST_HOLD_CYCLES  = pwr_seq_pkg::RST_HOLD_CYC,
	parameter int unsigned GRACE_CYCLES     = pwr_seq_pkg::GRACE_CYC,
	parameter int unsigned MIN_SLEEP_CYCLES = pwr_seq_pkg::MIN_SLEEP_CYC
) (
	input  wire logic                                clk_sys,
	input  wire logic                                sys_rst,
	input  wire pwr_seq_pkg::board_in_t              board,
	input  wire logic                                devices_idle,
	input  wire logic                                alarm_event,
	input  wire logic [pwr_seq_pkg::BUS0_WIDTH-1:0]  bus0_wake_req,
	input  wire pwr_seq_pkg::avmm_req_t              avmm,
	output logic [31:0]                              readdata,
	output logic                                     waitrequest,
	output logic                                     platform_reset_n,
	output logic                                     deep_sleep_rail_n,
	output logic                                     mgmt_interrupt,
	output logic                                     sci_interrupt
);

	typedef struct packed {
		logic                        cpg_s1;
		logic                        cpg_s2;
		logic                        cpg_d;
		logic                        rsm_s1;
		logic                        rsm_s2;
		logic                        rsm_d;
		logic                        btn_d;
		logic                        rbtn_d;
		pwr_seq_pkg::power_state_t   pstate;
		logic                        was_s4;
		logic                        after_fail;
		logic                        full_cycle;
		pwr_seq_pkg::rst_btn_state_t rb_state;
		logic [31:0]                 rb_cnt;
		logic [31:0]                 ovr_cnt;
		logic [31:0]                 str_cnt;
		logic [7:0]                  ctrl;
		logic [4:0]                  sts;
		logic                        wait_req;
		logic [31:0]                 rdata;
		logic                        mgmt;
		logic                        sci;
		logic                        rail_n;
		logic                        plat_low;
	} seq_state_t;

	seq_state_t state_reg;
	seq_state_t state_next;
	logic       btn_level;
	logic       rbtn_level;
	logic       plat_reg;
	logic       cpg_pin;

	// ----------------------------------------------------------------
	// Button debouncers
	// ----------------------------------------------------------------
	// Power button filter
	pwr_debounce #(
		.CYCLES   (DEBOUNCE_CYCLES)
	) u_pwr_btn (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.button_n (board.power_button_n),
		.pressed  (btn_level)
	);

	pwr_debounce #(
		.CYCLES   (DEBOUNCE_CYCLES)
	) u_rst_btn (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.button_n (board.reset_button_n),
		.pressed  (rbtn_level)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic                      btn_press;
		logic                      rb_press;
		logic                      stretch;
		logic                      req;
		logic                      do_wr;
		logic [4:0]                clr;
		logic                      go_s4;
		logic                      go_s5;
		logic                      rb_full;
		logic                      wake;
		logic [31:0]               rd;
		pwr_seq_pkg::power_state_t dest;
		btn_press = 1'b0;
		rb_press = 1'b0;
		stretch = 1'b0;
		req = 1'b0;
		do_wr = 1'b0;
		clr = 5'h00;
		go_s4 = 1'b0;
		go_s5 = 1'b0;
		rb_full = 1'b0;
		wake = 1'b0;
		rd = 32'h0;
		dest = pwr_seq_pkg::PS_S5;

		state_next = state_reg;
		state_next.cpg_s1 = board.core_power_good;
		state_next.cpg_s2 = state_reg.cpg_s1;
		state_next.cpg_d = state_reg.cpg_s2;
		state_next.rsm_s1 = board.suspend_well_reset_n;
		state_next.rsm_s2 = state_reg.rsm_s1;
		state_next.rsm_d = state_reg.rsm_s2;
		state_next.btn_d = btn_level;
		state_next.rbtn_d = rbtn_level;
		state_next.mgmt = 1'b0;

		// Act on the debounced press edge
		btn_press = btn_level & ~state_reg.btn_d;
		rb_press = rbtn_level & ~state_reg.rbtn_d;
		stretch = (state_reg.str_cnt != 32'h0);

		// ------------------------------------------------------------
		// Register bus: one wait state, then answer
		// ------------------------------------------------------------
		req = avmm.read | avmm.write;
		state_next.wait_req = 1'b1;
		unique case (avmm.address)
			pwr_seq_pkg::ADDR_CTRL: rd = {24'h0, state_reg.ctrl};
			pwr_seq_pkg::ADDR_STATUS: rd = {27'h0, state_reg.sts};
			pwr_seq_pkg::ADDR_LEVEL: begin
				rd[pwr_seq_pkg::LVL_BTN] = btn_level;
				rd[pwr_seq_pkg::LVL_STATE +: 2] = state_reg.pstate;
				rd[pwr_seq_pkg::LVL_PLT_RST] = ~plat_reg;
				rd[pwr_seq_pkg::LVL_STRETCH] = stretch;
				rd[pwr_seq_pkg::LVL_RB_BUSY] = (state_reg.rb_state != pwr_seq_pkg::RB_IDLE);
			end
			default: rd = 32'h0;
		endcase
		if (req && state_reg.wait_req) begin
			state_next.wait_req = 1'b0;
			state_next.rdata = rd;
		end
		do_wr = avmm.write & ~state_reg.wait_req & avmm.byteenable[0];
		if (do_wr) begin
			unique case (avmm.address)
				pwr_seq_pkg::ADDR_CTRL: state_next.ctrl = avmm.writedata[7:0];
				pwr_seq_pkg::ADDR_SLEEP: begin
					go_s5 = avmm.writedata[pwr_seq_pkg::SLEEP_S5];
					go_s4 = avmm.writedata[pwr_seq_pkg::SLEEP_S4];
				end
				pwr_seq_pkg::ADDR_STATUS: clr = avmm.writedata[4:0];
				default: clr = 5'h00;
			endcase
		end

		// ------------------------------------------------------------
		// Status flags: hardware set wins over software clear
		// ------------------------------------------------------------
		state_next.sts = state_reg.sts & ~clr;
		if (btn_press && state_reg.pstate != pwr_seq_pkg::PS_G3) begin
			state_next.sts[pwr_seq_pkg::STS_BTN] = 1'b1;
		end
		if (alarm_event && state_reg.pstate != pwr_seq_pkg::PS_G3) begin
			state_next.sts[pwr_seq_pkg::STS_ALARM] = 1'b1;
		end
		if (|bus0_wake_req) begin
			state_next.sts[pwr_seq_pkg::STS_BUS0] = 1'b1;
		end
		if (state_reg.cpg_d && !state_reg.cpg_s2) begin
			state_next.sts[pwr_seq_pkg::STS_CORE_PF] = 1'b1;
		end
		if (state_reg.rsm_d && !state_reg.rsm_s2) begin
			state_next.sts[pwr_seq_pkg::STS_SUS_PF] = 1'b1;
		end
		// Held clear while suspend well is in reset
		if (!state_reg.rsm_s2) begin
			state_next.sts[pwr_seq_pkg::STS_BTN] = 1'b0;
			state_next.sts[pwr_seq_pkg::STS_ALARM] = 1'b0;
		end

		// Press in S0 raises SMI when CTRL_BTN_IRQ and CTRL_GBL_MGMT are set and CTRL_SCI_SEL is clear
		if (btn_press && state_reg.pstate == pwr_seq_pkg::PS_S0
				&& state_reg.ctrl[pwr_seq_pkg::CTRL_BTN_IRQ]
				&& !state_reg.ctrl[pwr_seq_pkg::CTRL_SCI_SEL]
				&& state_reg.ctrl[pwr_seq_pkg::CTRL_GBL_MGMT]) begin
			state_next.mgmt = 1'b1;
		end
		// SCI is a level: stays up until the status is cleared
		state_next.sci = state_next.sts[pwr_seq_pkg::STS_BTN]
			& state_reg.ctrl[pwr_seq_pkg::CTRL_BTN_IRQ]
			& state_reg.ctrl[pwr_seq_pkg::CTRL_SCI_SEL];

		// ------------------------------------------------------------
		// Timers
		// ------------------------------------------------------------
		if (stretch) begin
			state_next.str_cnt = state_reg.str_cnt - 32'h1;
		end
		// Override counts in S0 only, never during stretch
		if (state_reg.pstate == pwr_seq_pkg::PS_S0 && btn_level && !stretch) begin
			state_next.ovr_cnt = state_reg.ovr_cnt + 32'h1;
		end else begin
			state_next.ovr_cnt = 32'h0;
		end

		// ------------------------------------------------------------
		// Reset button sequence
		// ------------------------------------------------------------
		unique case (state_reg.rb_state)
			pwr_seq_pkg::RB_IDLE: begin
				if (rb_press && state_reg.pstate == pwr_seq_pkg::PS_S0) begin
					// Full power-cycle instead of plain reset
					if (state_reg.ctrl[pwr_seq_pkg::CTRL_FULL_RST]) begin
						rb_full = 1'b1;
						state_next.rb_state = pwr_seq_pkg::RB_BLOCK;
					end else if (devices_idle) begin
						state_next.rb_state = pwr_seq_pkg::RB_HOLD;
						state_next.rb_cnt = RST_HOLD_CYCLES - 1;
					end else begin
						state_next.rb_state = pwr_seq_pkg::RB_WAIT;
						state_next.rb_cnt = GRACE_CYCLES - 1;
					end
				end
			end
			pwr_seq_pkg::RB_WAIT: begin
				if (devices_idle || state_reg.rb_cnt == 32'h0) begin
					state_next.rb_state = pwr_seq_pkg::RB_HOLD;
					state_next.rb_cnt = RST_HOLD_CYCLES - 1;
				end else begin
					state_next.rb_cnt = state_reg.rb_cnt - 32'h1;
				end
			end
			pwr_seq_pkg::RB_HOLD: begin
				if (state_reg.rb_cnt == 32'h0) begin
					state_next.rb_state = pwr_seq_pkg::RB_BLOCK;
				end else begin
					state_next.rb_cnt = state_reg.rb_cnt - 32'h1;
				end
			end
			pwr_seq_pkg::RB_BLOCK: begin
				// Rearm only after release in full S0
				if (!rbtn_level && state_reg.pstate == pwr_seq_pkg::PS_S0 && plat_reg) begin
					state_next.rb_state = pwr_seq_pkg::RB_IDLE;
				end
			end
		endcase

		// ------------------------------------------------------------
		// Power state machine
		// ------------------------------------------------------------
		// Only button or alarm after a power failure
		wake = btn_press
			|| (btn_level && state_reg.str_cnt == 32'h1)
			|| (state_reg.sts[pwr_seq_pkg::STS_ALARM] && state_reg.ctrl[pwr_seq_pkg::CTRL_ALARM_EN])
			|| (|bus0_wake_req && !state_reg.after_fail)
			|| state_reg.full_cycle;
		if (!state_reg.rsm_s2) begin
			if (state_reg.pstate != pwr_seq_pkg::PS_G3) begin
				state_next.was_s4 = (state_reg.pstate == pwr_seq_pkg::PS_S4);
			end
			state_next.pstate = pwr_seq_pkg::PS_G3;
			state_next.full_cycle = 1'b0;
			state_next.str_cnt = 32'h0;
		end else begin
			unique case (state_reg.pstate)
				pwr_seq_pkg::PS_G3: begin
					state_next.after_fail = 1'b1;
					if (state_reg.ctrl[pwr_seq_pkg::CTRL_STAY_OFF]) begin
						state_next.pstate = state_reg.was_s4 ? pwr_seq_pkg::PS_S4
							: pwr_seq_pkg::PS_S5;
					end else begin
						state_next.pstate = pwr_seq_pkg::PS_S0;
						state_next.after_fail = 1'b0;
					end
				end
				pwr_seq_pkg::PS_S0: begin
					// Override wins over everything but suspend well reset and a full power-cycle request, core power ignored
					if (state_reg.ovr_cnt == OVERRIDE_CYCLES - 1 || go_s5 || rb_full || go_s4) begin
						dest = (go_s4 && !go_s5 && !rb_full
							&& state_reg.ovr_cnt != OVERRIDE_CYCLES - 1)
							? pwr_seq_pkg::PS_S4 : pwr_seq_pkg::PS_S5;
						state_next.pstate = dest;
						state_next.full_cycle = rb_full;
						if (rb_full) begin
							state_next.str_cnt = RST_HOLD_CYCLES;
						end else if (state_reg.ctrl[pwr_seq_pkg::CTRL_MIN_SLEEP]) begin
							state_next.str_cnt = MIN_SLEEP_CYCLES;
						end
					end
				end
				pwr_seq_pkg::PS_S4, pwr_seq_pkg::PS_S5: begin
					// Wake to S0 once stretch is over
					if (wake && (!stretch || state_reg.str_cnt == 32'h1)) begin
						state_next.pstate = pwr_seq_pkg::PS_S0;
						state_next.after_fail = 1'b0;
						state_next.full_cycle = 1'b0;
					end
				end
			endcase
		end

		state_next.rail_n = (state_next.pstate == pwr_seq_pkg::PS_S0);
		state_next.plat_low = (state_next.pstate != pwr_seq_pkg::PS_S0)
			|| (state_next.rb_state == pwr_seq_pkg::RB_HOLD)
			|| !state_reg.cpg_s2;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '0;
			state_reg.pstate <= pwr_seq_pkg::PS_G3;
			state_reg.rb_state <= pwr_seq_pkg::RB_IDLE;
			state_reg.ctrl <= pwr_seq_pkg::CTRL_RESET;
			state_reg.sts <= pwr_seq_pkg::STS_RESET;
			state_reg.wait_req <= 1'b1;
			state_reg.plat_low <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Platform reset bypasses the synchroniser so it asserts with no clock
	assign cpg_pin = board.core_power_good;

	// Asynchronous assertion on core power loss
	always_ff @(posedge clk_sys or posedge sys_rst or negedge cpg_pin) begin
		if (sys_rst) begin
			plat_reg <= 1'b0;
		end else if (!cpg_pin) begin
			plat_reg <= 1'b0;
		end else begin
			plat_reg <= ~state_next.plat_low;
		end
	end

	assign readdata = state_reg.rdata;
	assign waitrequest = state_reg.wait_req;
	assign platform_reset_n = plat_reg;
	assign deep_sleep_rail_n = state_reg.rail_n;
	assign mgmt_interrupt = state_reg.mgmt;
	assign sci_interrupt = state_reg.sci;

endmodule : power_event_sequencer

// [tb/power_event_sequencer_chk.sv]
// Assertion checker for the power event sequencer ports
`timescale 1ns/1ps
module power_event_sequencer_chk #(
	parameter int unsigned DEBOUNCE_CYCLES = 8,
	parameter int unsigned OVERRIDE_CYCLES = 64,
	parameter int unsigned RST_HOLD_CYCLES = 20,
	parameter int unsigned GRACE_CYCLES    = 16
) (
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire pwr_seq_pkg::board_in_t board,
	input wire pwr_seq_pkg::avmm_req_t avmm,
	input wire logic                   waitrequest,
	input wire logic                   platform_reset_n,
	input wire logic                   deep_sleep_rail_n,
	input wire logic                   mgmt_interrupt,
	input wire logic                   sci_interrupt
);
	typedef struct packed {
		logic [15:0] btn_lo;
		logic [15:0] btn_s0;
		logic [15:0] prst_lo;
		logic [15:0] rb_wait;
		logic        rb_done;
		logic        rb_rst;
	} watch_t;
	watch_t w_reg;
	watch_t w_next;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// ----------------------------------------------------------------
	// Cycle counters
	// ----------------------------------------------------------------
	always_comb begin
		w_next = w_reg;
		w_next.btn_lo = board.power_button_n ? 16'h0 : w_reg.btn_lo + 16'h1;
		w_next.btn_s0 = (board.power_button_n || !deep_sleep_rail_n) ? 16'h0 : w_reg.btn_s0 + 16'h1;
		w_next.prst_lo = platform_reset_n ? 16'h0 : w_reg.prst_lo + 16'h1;
		w_next.rb_done = !board.reset_button_n && (w_reg.rb_done || !platform_reset_n);
		w_next.rb_wait = (board.reset_button_n || w_reg.rb_done || !platform_reset_n
			|| !deep_sleep_rail_n) ? 16'h0 : w_reg.rb_wait + 16'h1;
		w_next.rb_rst = !platform_reset_n && (w_reg.rb_rst
			|| (!board.reset_button_n && deep_sleep_rail_n));
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			w_reg <= '0;
		end else begin
			w_reg <= w_next;
		end
	end
	sequence s_answer;
		!waitrequest ##1 waitrequest;
	endsequence
	sequence s_in_g3;
		!board.suspend_well_reset_n [*6];
	endsequence
	// One wait state per request
	a_bus_answer: assert property ((avmm.read || avmm.write) && waitrequest |=> s_answer)
		else $error("bus answer not one cycle");
	a_core_loss_reset: assert property (!board.core_power_good |-> !platform_reset_n)
		else $error("platform reset idle without core power");
	a_g3_quiet: assert property (s_in_g3 |-> !deep_sleep_rail_n && !mgmt_interrupt && !sci_interrupt)
		else $error("activity while suspend well is down");
	a_mgmt_pulse: assert property (mgmt_interrupt |=> !mgmt_interrupt)
		else $error("management interrupt longer than one cycle");
	a_debounce_min: assert property ($rose(mgmt_interrupt) |-> w_reg.btn_lo >= DEBOUNCE_CYCLES)
		else $error("press acted on before debounce ended");
	a_override_max: assert property (w_reg.btn_s0 <= DEBOUNCE_CYCLES + OVERRIDE_CYCLES + 8)
		else $error("held button did not force off");
	a_override_min: assert property ($fell(deep_sleep_rail_n) && !board.power_button_n
		|-> w_reg.btn_s0 >= OVERRIDE_CYCLES - 2) else $error("override came too early");
	a_grace_bound: assert property (w_reg.rb_wait <= DEBOUNCE_CYCLES + GRACE_CYCLES + 8)
		else $error("reset button reset not forced in time");
	a_rst_hold: assert property ($rose(platform_reset_n) && w_reg.rb_rst
		|-> w_reg.prst_lo >= RST_HOLD_CYCLES) else $error("reset button reset too short");
	a_rb_rearm: assert property ($rose(platform_reset_n) && w_reg.rb_rst
		&& !board.reset_button_n |=> platform_reset_n [*8]) else $error("reset repeated while held");
endmodule : power_event_sequencer_chk

bind power_event_sequencer power_event_sequencer_chk #(
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
	.OVERRIDE_CYCLES(OVERRIDE_CYCLES),
	.RST_HOLD_CYCLES(RST_HOLD_CYCLES),
	.GRACE_CYCLES(GRACE_CYCLES)
) u_power_event_sequencer_chk (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.board(board),
	.avmm(avmm),
	.waitrequest(waitrequest),
	.platform_reset_n(platform_reset_n),
	.deep_sleep_rail_n(deep_sleep_rail_n),
	.mgmt_interrupt(mgmt_interrupt),
	.sci_interrupt(sci_interrupt)
);

// [tb/board_model.sv]
// Board model: buttons with pull-ups and supply monitors
`timescale 1ns/1ps
module board_model (
	input  wire logic              pwr_press,
	input  wire logic              rst_press,
	input  wire logic              core_ok,
	input  wire logic              sus_ok,
	output pwr_seq_pkg::board_in_t board
);
	// user holds button
	// Released buttons sit at the pull-up level
	assign board = '{~pwr_press, ~rst_press, core_ok, sus_ok};
endmodule : board_model

// [tb/tb_power_event_sequencer.sv]
// Self-checking bench for the power event sequencer
`timescale 1ns/1ps
module tb_power_event_sequencer;
	typedef struct packed {
		logic [3:0]  a;
		logic        wr;
		logic        be;
		logic [31:0] d;
	} row_t;
	// Short counts keep the run brief
	localparam int DEB  = 8;
	localparam int OVR  = 64;
	localparam int HLD  = 20;
	localparam int GRC  = 16;
	localparam int SLP  = 40;
	localparam int MGMT = 0;
	localparam int SCI  = 1;
	localparam int RAIL = 2;
	localparam int PRST = 3;
	logic                   clk_sys;
	logic                   sys_rst;
	logic                   devices_idle;
	logic                   alarm_event;
	logic                   pwr_press;
	logic                   rst_press;
	logic                   core_ok;
	logic                   sus_ok;
	logic [3:0]             bus0_wake_req;
	pwr_seq_pkg::avmm_req_t avmm;
	pwr_seq_pkg::board_in_t board;
	logic [31:0]            readdata;
	logic [31:0]            q;
	logic                   waitrequest;
	logic                   platform_reset_n;
	logic                   deep_sleep_rail_n;
	logic                   mgmt_interrupt;
	logic                   sci_interrupt;
	int                     num_errors;
	int                     checks_done;
	row_t rows [10] = '{
		'{4'h0, 1'b0, 1'b1, 32'h0},
		'{4'h8, 1'b0, 1'b1, 32'h0},
		'{4'hc, 1'b0, 1'b1, 32'h4},
		'{4'h4, 1'b0, 1'b1, 32'h0},
		'{4'h2, 1'b1, 1'b1, 32'hff},
		'{4'h2, 1'b0, 1'b1, 32'h0},
		'{4'h0, 1'b1, 1'b1, 32'h4e},
		'{4'h0, 1'b1, 1'b0, 32'h0},
		'{4'h0, 1'b0, 1'b1, 32'h4e},
		'{4'h0, 1'b1, 1'b1, 32'hc}
	};
	board_model u_board_model (
		.pwr_press(pwr_press),
		.rst_press(rst_press),
		.core_ok(core_ok),
		.sus_ok(sus_ok),
		.board(board)
	);
	power_event_sequencer #(
		.DEBOUNCE_CYCLES(DEB),
		.OVERRIDE_CYCLES(OVR),
		.RST_HOLD_CYCLES(HLD),
		.GRACE_CYCLES(GRC),
		.MIN_SLEEP_CYCLES(SLP)
	) u_power_event_sequencer (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.board(board),
		.devices_idle(devices_idle),
		.alarm_event(alarm_event),
		.bus0_wake_req(bus0_wake_req),
		.avmm(avmm),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.platform_reset_n(platform_reset_n),
		.deep_sleep_rail_n(deep_sleep_rail_n),
		.mgmt_interrupt(mgmt_interrupt),
		.sci_interrupt(sci_interrupt)
	);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic give_verdict;
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tk
	task automatic bus(input logic [3:0] a, input logic wr, input logic be, input logic [31:0] d);
		int n;
		n = 0;
		avmm <= '{a, !wr, wr, d, {3'h0, be}};
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		avmm.read <= 1'b0;
		avmm.write <= 1'b0;
		@(posedge clk_sys);
		if (n >= 50) begin
			chk("bus answer", 32'h1, 32'h0);
			give_verdict();
		end
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(a, 1'b1, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(a, 1'b0, 1'b1, 32'h0);
		chk("register", q & m, e);
	endtask : rd
	function automatic logic sig(input int w);
		case (w)
			MGMT: return mgmt_interrupt;
			SCI: return sci_interrupt;
			RAIL: return deep_sleep_rail_n;
			default: return platform_reset_n;
		endcase
	endfunction : sig
	// A limit of zero checks the level at once
	task automatic wait_sig(input int w, input logic v, input int lim);
		int n;
		n = 0;
		while (sig(w) !== v && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		chk("output level", {31'h0, sig(w)}, {31'h0, v});
		if (sig(w) !== v) give_verdict();
	endtask : wait_sig
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		tk(20000);
		chk("run time", 32'h1, 32'h0);
		give_verdict();
	end
	initial begin
		num_errors = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		devices_idle = 1'b1;
		alarm_event = 1'b0;
		pwr_press = 1'b0;
		rst_press = 1'b0;
		core_ok = 1'b1;
		sus_ok = 1'b1;
		bus0_wake_req = 4'h0;
		avmm = '0;
		tk(2);
		sys_rst <= 1'b0;
		tk(10);
		wait_sig(RAIL, 1'b1, 0);
		foreach (rows[i]) begin
			bus(rows[i].a, rows[i].wr, rows[i].be, rows[i].d);
			if (!rows[i].wr) chk("register", q, rows[i].d);
		end
		pwr_press <= 1'b1;
		wait_sig(MGMT, 1'b1, DEB + 20);
		wait_sig(SCI, 1'b0, 0);
		rd(4'h8, 32'h1, 32'h1);
		rd(4'hc, 32'h1, 32'h1);
		pwr_press <= 1'b0;
		tk(DEB + 6);
		rd(4'hc, 32'h1, 32'h0);
		wr(4'h8, 32'h1);
		wr(4'h0, 32'he);
		pwr_press <= 1'b1;
		wait_sig(SCI, 1'b1, DEB + 20);
		pwr_press <= 1'b0;
		tk(DEB + 6);
		wr(4'h8, 32'h1);
		tk(2);
		wait_sig(SCI, 1'b0, 0);
		pwr_press <= 1'b1;
		tk(DEB - 3);
		pwr_press <= 1'b0;
		tk(DEB + 6);
		rd(4'h8, 32'h1, 32'h0);
		pwr_press <= 1'b1;
		wait_sig(RAIL, 1'b0, DEB + OVR + 20);
		rd(4'hc, 32'hc, 32'hc);
		pwr_press <= 1'b0;
		tk(DEB + 6);
		pwr_press <= 1'b1;
		wait_sig(RAIL, 1'b1, DEB + 20);
		pwr_press <= 1'b0;
		tk(DEB + 6);
		wr(4'h0, 32'h1c);
		wr(4'h4, 32'h1);
		pwr_press <= 1'b1;
		tk(SLP / 2);
		wait_sig(RAIL, 1'b0, 0);
		wait_sig(RAIL, 1'b1, SLP + DEB + 20);
		wait_sig(RAIL, 1'b0, OVR + 20);
		pwr_press <= 1'b0;
		tk(SLP + DEB + 10);
		wait_sig(RAIL, 1'b0, 0);
		pwr_press <= 1'b1;
		wait_sig(RAIL, 1'b1, DEB + 20);
		pwr_press <= 1'b0;
		tk(DEB + 6);
		wr(4'h0, 32'hc);
		rst_press <= 1'b1;
		wait_sig(PRST, 1'b0, DEB + 10);
		wait_sig(PRST, 1'b1, HLD + 30);
		tk(30);
		wait_sig(PRST, 1'b1, 0);
		rst_press <= 1'b0;
		tk(DEB + 8);
		devices_idle <= 1'b0;
		rst_press <= 1'b1;
		tk(DEB + 6);
		wait_sig(PRST, 1'b1, 0);
		wait_sig(PRST, 1'b0, GRC + 10);
		rst_press <= 1'b0;
		devices_idle <= 1'b1;
		wait_sig(PRST, 1'b1, HLD + 30);
		tk(DEB + 8);
		wr(4'h0, 32'h2c);
		rst_press <= 1'b1;
		wait_sig(RAIL, 1'b0, DEB + GRC + 10);
		rst_press <= 1'b0;
		wait_sig(RAIL, 1'b1, HLD + 40);
		tk(DEB + 8);
		wr(4'h0, 32'h4d);
		wr(4'h8, 32'h1f);
		core_ok <= 1'b0;
		#1;
		wait_sig(PRST, 1'b0, 0);
		@(posedge clk_sys);
		sus_ok <= 1'b0;
		tk(8);
		pwr_press <= 1'b1;
		tk(DEB + 8);
		pwr_press <= 1'b0;
		tk(DEB + 8);
		sus_ok <= 1'b1;
		core_ok <= 1'b1;
		tk(10);
		rd(4'h8, 32'h1f, 32'hc);
		rd(4'hc, 32'hc, 32'hc);
		bus0_wake_req <= 4'h1;
		tk(6);
		wait_sig(RAIL, 1'b0, 0);
		bus0_wake_req <= 4'h0;
		alarm_event <= 1'b1;
		tk(1);
		alarm_event <= 1'b0;
		wait_sig(RAIL, 1'b1, 20);
		wr(4'h8, 32'h1f);
		bus0_wake_req <= 4'h2;
		tk(2);
		bus0_wake_req <= 4'h0;
		rd(4'h8, 32'h10, 32'h10);
		alarm_event <= 1'b1;
		tk(1);
		alarm_event <= 1'b0;
		tk(2);
		rd(4'h8, 32'h2, 32'h2);
		wr(4'h0, 32'h4c);
		sus_ok <= 1'b0;
		tk(8);
		sus_ok <= 1'b1;
		wait_sig(RAIL, 1'b1, 20);
		rd(4'h8, 32'h3, 32'h0);
		wr(4'h4, 32'h2);
		rd(4'hc, 32'hc, 32'h8);
		pwr_press <= 1'b1;
		wait_sig(RAIL, 1'b1, DEB + 20);
		pwr_press <= 1'b0;
		give_verdict();
	end
endmodule : tb_power_event_sequencer
